// [rstwd_pkg.sv]
// package: constants, register map and types for the reset and watchdog controller
package rstwd_pkg;
    // ==========================================================
    // register map (byte addresses on the apb bus)
    localparam logic [11:0] ADDR_WDOG_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_RST_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_ANALOG_CTRL = 12'h008;
    localparam logic [11:0] ADDR_WDOG_CMD    = 12'h00C;
    // ==========================================================
    // watchdog control field positions
    localparam int WDC_IRQ_FLAG   = 7;
    localparam int WDC_IRQ_ENABLE = 6;
    localparam int WDC_PERIOD_HI  = 5;
    localparam int WDC_UNLOCK     = 4;
    localparam int WDC_RST_ENABLE = 3;
    // reset status field positions
    localparam int RS_TEST_PORT   = 4;
    localparam int RS_WDOG        = 3;
    localparam int RS_BROWNOUT    = 2;
    localparam int RS_EXTERNAL    = 1;
    localparam int RS_SUPPLY      = 0;
    // analog control field positions
    localparam int AC_BANDGAP_SEL = 0;
    localparam int AC_CONV_ENABLE = 1;
    // command register: bit 0 restarts the watchdog, bit 1 acks the irq vector
    localparam int CMD_RESTART    = 0;
    localparam int CMD_IRQ_ACK    = 1;
    // ==========================================================
    // reset values
    localparam logic [7:0] WDOG_CTRL_RESET  = 8'h00;
    localparam logic [4:0] RST_STATUS_RESET = 5'h01;
    // ==========================================================
    // timing
    localparam int  UNLOCK_WINDOW_CYC = 4;
    localparam int  WDOG_BASE_SHIFT   = 11;  // code 0 counts 2048 oscillator cycles
    localparam int  WDOG_CODE_MAX     = 9;   // 8 s at 128 kHz
    localparam int  WDOG_OSC_HZ       = 128000;
    localparam int  SYS_CLOCK_HZ      = 10000000;
    localparam int  WDOG_TICK_DIV     = SYS_CLOCK_HZ / WDOG_OSC_HZ;
    localparam int  RELEASE_DELAY_CYC = 64;
    // ==========================================================
    // types
    typedef struct packed {
        logic supply_low;
        logic ext_pin_low;
        logic brownout_low;
        logic test_port_rst;
    } rst_src_t;

    typedef struct packed {
        logic       irq_enable;
        logic       rst_enable;
        logic [3:0] period_select;
    } wdog_cfg_t;
endpackage : rstwd_pkg

// [release_delay.sv]
// release delay counter that stretches the internal reset after the last source drops
`timescale 1ns/1ps
`default_nettype none
module release_delay #(
    parameter int MAX_CYC = 4096
) (
    input  wire logic        i_clock,
    input  wire logic        i_hold,
    input  wire logic [11:0] i_delay_cyc,
    output logic             o_reset_active
);
    import rstwd_pkg::*;

    logic [11:0] count_r;

    initial begin
        if (MAX_CYC < 1 || MAX_CYC > 4096) $error("release_delay: bad MAX_CYC");
    end

    // restarts on any held source; counts down once all sources are gone
    always_ff @(posedge i_clock) begin
        if (i_hold) begin
            count_r <= i_delay_cyc;
        end else if (count_r != 12'h000) begin
            count_r <= count_r - 12'h001;
        end
    end

    // combinational so a new source asserts the reset with no added delay
    assign o_reset_active = i_hold || (count_r != 12'h000);
endmodule : release_delay
`default_nettype wire

// [reset_and_watchdog_control.sv]
// reset combiner, release stretch, bandgap enable and enhanced watchdog with apb access
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - internal reset returns all registers but the reset cause flags to initial values; core restarts at vector; tick divider, pulse and read data keep theirs
// - port reset output is a pure combinational OR, needing no clock
// - after all sources go inactive, reset stays on for a fuse-chosen count
// - five sources: supply-up, pin, watchdog, brown-out, test-port register
// - external pin low asserts reset combinationally, clock or not
// - watchdog expiry gives a one-cycle pulse; delay count starts after it
// - reset held while the test-port reset bit is one
// - supply-up release starts delay; supply drop reasserts at once
// - enabled brown-out asserts at once; recovery starts the delay
// - bandgap on if brown-out fused on, comparator selects it, or converter on
// - watchdog counts 128 kHz ticks and fires at the selected time-out
// - restart clears the watchdog counter; otherwise expiry takes its action
// - interrupt mode raises an interrupt usable as a wake-up
// - combined mode sets the irq flag and drops to reset-only mode on the same expiry, so the irq output stays low
// - period selectable from 16 ms to 8 s
// - force-on fuse locks reset enable at 1 and irq enable at 0
// - within four cycles, one write with unlock clear sets enable and period
// - unlock bit clears itself four cycles after being set
// - while watchdog reset flag is set, reset enable reads one, cannot clear
// - irq flag set on expiry, cleared by vector ack or writing one
module reset_and_watchdog_control #(
    parameter int DELAY_MAX_CYC = 4096
) (
    input  wire logic                  i_clock,
    input  wire logic                  i_sys_rst,
    input  wire rstwd_pkg::rst_src_t   i_sources,
    input  wire logic [2:0]            i_brownout_level_fuse,
    input  wire logic [1:0]            i_startup_time_fuse,
    input  wire logic [3:0]            i_clock_select_fuse,
    input  wire logic                  i_wdog_force_on_fuse,
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [11:0]           i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic                       o_pready,
    output logic                       o_pslverr,
    output logic [31:0]                o_prdata,
    output logic                       o_port_reset,
    output logic                       o_core_reset,
    output logic                       o_wdog_irq,
    output logic                       o_bandgap_enable
);
    import rstwd_pkg::*;

    initial begin
        if (DELAY_MAX_CYC < 64 || DELAY_MAX_CYC > 4096) $error("bad DELAY_MAX_CYC");
    end

    // ==========================================================
    // functions
    function automatic logic [21:0] wdog_limit(input logic [3:0] code);
        logic [3:0] c;
        c = (code > 4'(WDOG_CODE_MAX)) ? 4'(WDOG_CODE_MAX) : code;
        return 22'(22'h000001 << (WDOG_BASE_SHIFT + int'(c)));
    endfunction

    function automatic logic [11:0] fuse_delay(input logic [1:0] startup_time_fuse, input logic [3:0] ck);
        logic [11:0] d;
        d = 12'(RELEASE_DELAY_CYC) << startup_time_fuse;
        return (ck[0]) ? 12'(d << 1) : d;
    endfunction

    // ==========================================================
    // apb decode
    logic wr_en, rd_en;
    logic mapped;
    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign rd_en     = i_psel && i_penable && !i_pwrite;
    assign o_pready  = 1'b1;  // zero wait states keeps the unlock window exact
    assign mapped    = (i_paddr == ADDR_WDOG_CTRL) || (i_paddr == ADDR_RST_STATUS) ||
                       (i_paddr == ADDR_ANALOG_CTRL) || (i_paddr == ADDR_WDOG_CMD);
    assign o_pslverr = i_psel && i_penable && !mapped;

    logic wr_ctrl, wr_status, wr_analog, wr_cmd;
    assign wr_ctrl   = wr_en && (i_paddr == ADDR_WDOG_CTRL);
    assign wr_status = wr_en && (i_paddr == ADDR_RST_STATUS);
    assign wr_analog = wr_en && (i_paddr == ADDR_ANALOG_CTRL);
    assign wr_cmd    = wr_en && (i_paddr == ADDR_WDOG_CMD);

    // ==========================================================
    // reset combining
    logic brownout_enabled;
    logic wdog_pulse_r;
    logic hold_sources;
    logic stretched;
    assign brownout_enabled = (i_brownout_level_fuse != 3'b111);
    // purely combinational so the ports reset without any clock
    assign hold_sources = i_sources.supply_low
                        || i_sources.ext_pin_low
                        || (brownout_enabled && i_sources.brownout_low)
                        || i_sources.test_port_rst
                        || wdog_pulse_r;
    assign o_port_reset = hold_sources || stretched;

    release_delay #(.MAX_CYC(DELAY_MAX_CYC)) u_delay (
        .i_clock        (i_clock),
        .i_hold         (hold_sources),
        .i_delay_cyc    (fuse_delay(i_startup_time_fuse, i_clock_select_fuse)),
        .o_reset_active (stretched)
    );
    // internal reset drives the core back to its vector and clears our registers except the reset cause flags, tick divider, pulse and read data
    assign o_core_reset = stretched;

    logic rst_all;
    assign rst_all = i_sys_rst || stretched;

    // ==========================================================
    // watchdog tick divider (stand-in for the 128 kHz oscillator)
    logic [7:0] tick_div_r;
    logic       wd_tick;
    assign wd_tick = (tick_div_r == 8'(WDOG_TICK_DIV - 1));
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || wd_tick) begin
            tick_div_r <= 8'h00;
        end else begin
            tick_div_r <= tick_div_r + 8'h01;
        end
    end

    // ==========================================================
    // watchdog configuration and flags
    wdog_cfg_t  cfg_r;
    logic       unlock_r;
    logic [2:0] unlock_cnt_r;
    logic       irq_flag_r;
    logic       wdog_rst_flag_r;
    logic       wd_expire;
    logic       eff_rst_en;
    logic       eff_irq_en;
    logic [3:0] wr_period;
    logic       wr_unlock_seq;

    assign wr_period     = {i_pwdata[WDC_PERIOD_HI], i_pwdata[2:0]};
    assign wr_unlock_seq = wr_ctrl && i_pwdata[WDC_UNLOCK] && i_pwdata[WDC_RST_ENABLE];
    assign eff_rst_en    = i_wdog_force_on_fuse || wdog_rst_flag_r || cfg_r.rst_enable;
    assign eff_irq_en    = !i_wdog_force_on_fuse && cfg_r.irq_enable;

    // unlock window: self-clearing after four cycles
    always_ff @(posedge i_clock) begin
        if (rst_all) begin
            unlock_r     <= 1'b0;
            unlock_cnt_r <= 3'h0;
        end else if (wr_unlock_seq) begin
            unlock_r     <= 1'b1;
            unlock_cnt_r <= 3'(UNLOCK_WINDOW_CYC);
        end else if (unlock_cnt_r != 3'h0) begin
            unlock_cnt_r <= unlock_cnt_r - 3'h1;
            unlock_r     <= (unlock_cnt_r != 3'h1);
        end
    end

    // configuration: protected fields only move inside the window
    always_ff @(posedge i_clock) begin
        if (rst_all) begin
            cfg_r <= '{irq_enable: 1'b0, rst_enable: 1'b0, period_select: 4'h0};
        end else begin
            if (wr_ctrl) begin
                cfg_r.irq_enable <= i_pwdata[WDC_IRQ_ENABLE];
                if (i_pwdata[WDC_RST_ENABLE]) begin
                    cfg_r.rst_enable <= 1'b1;               // setting is always allowed
                end else if (unlock_r && !i_pwdata[WDC_UNLOCK]) begin
                    cfg_r.rst_enable <= 1'b0;
                end
                if (unlock_r && !i_pwdata[WDC_UNLOCK]) begin
                    cfg_r.period_select <= wr_period;
                end
            end else if (wd_expire && eff_irq_en && cfg_r.rst_enable) begin
                cfg_r.irq_enable <= 1'b0;   // combined mode falls back to reset
            end else if (wr_cmd && i_pwdata[CMD_IRQ_ACK] && cfg_r.rst_enable) begin
                cfg_r.irq_enable <= 1'b0;   // vector taken in combined mode
            end
        end
    end

    // watchdog counter
    logic [21:0] wd_count_r;
    logic        wd_running;
    assign wd_running = eff_rst_en || eff_irq_en;
    assign wd_expire  = wd_running && wd_tick &&
                        (wd_count_r + 22'h000001 >= wdog_limit(cfg_r.period_select));
    always_ff @(posedge i_clock) begin
        if (rst_all || !wd_running || (wr_cmd && i_pwdata[CMD_RESTART]) || wd_expire) begin
            wd_count_r <= 22'h000000;
        end else if (wd_tick) begin
            wd_count_r <= wd_count_r + 22'h000001;
        end
    end

    // one-cycle reset pulse; the delay starts as it falls
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wdog_pulse_r <= 1'b0;
        end else begin
            wdog_pulse_r <= wd_expire && eff_rst_en && !eff_irq_en;
        end
    end

    // interrupt flag: set wins over clear
    always_ff @(posedge i_clock) begin
        if (rst_all) begin
            irq_flag_r <= 1'b0;
        end else if (wd_expire && eff_irq_en) begin
            irq_flag_r <= 1'b1;
        end else if ((wr_ctrl && i_pwdata[WDC_IRQ_FLAG]) ||
                     (wr_cmd && i_pwdata[CMD_IRQ_ACK])) begin
            irq_flag_r <= 1'b0;
        end
    end
    // level output from the flag and the effective irq enable, usable as a wake source
    assign o_wdog_irq = irq_flag_r && eff_irq_en;

    // ==========================================================
    // reset cause flags, not cleared by the internal reset itself
    logic [4:0] cause_r;
    logic [4:0] cause_set;
    assign cause_set = {i_sources.test_port_rst, wdog_pulse_r,
                        brownout_enabled && i_sources.brownout_low,
                        i_sources.ext_pin_low, i_sources.supply_low};
    assign wdog_rst_flag_r = cause_r[RS_WDOG];
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            cause_r <= RST_STATUS_RESET;
        end else begin
            // set beats a software clear in the same cycle
            cause_r <= (wr_status ? (cause_r & i_pwdata[4:0]) : cause_r) | cause_set;
        end
    end

    // ==========================================================
    // analog control and bandgap enable
    logic bandgap_sel_r;
    logic conv_enable_r;
    always_ff @(posedge i_clock) begin
        if (rst_all) begin
            bandgap_sel_r <= 1'b0;
            conv_enable_r <= 1'b0;
        end else if (wr_analog) begin
            bandgap_sel_r <= i_pwdata[AC_BANDGAP_SEL];
            conv_enable_r <= i_pwdata[AC_CONV_ENABLE];
        end
    end
    // start-up wait after enabling is left to firmware
    assign o_bandgap_enable = brownout_enabled || bandgap_sel_r || conv_enable_r;

    // ==========================================================
    // read data, registered
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            case (i_paddr)
                ADDR_WDOG_CTRL:   o_prdata <= {24'h000000, irq_flag_r, eff_irq_en,
                                               cfg_r.period_select[3], unlock_r,
                                               eff_rst_en, cfg_r.period_select[2:0]};
                ADDR_RST_STATUS:  o_prdata <= {27'h0000000, cause_r};
                ADDR_ANALOG_CTRL: o_prdata <= {30'h00000000, conv_enable_r, bandgap_sel_r};
                default:          o_prdata <= 32'h00000000;
            endcase
        end
    end
endmodule : reset_and_watchdog_control
`default_nettype wire

// [rstwd_monitor.sv]
// checker: port-level assertions for the reset and watchdog controller
`timescale 1ns/1ps
`default_nettype none
module rstwd_monitor
    import rstwd_pkg::*;
(
    input wire logic                i_clock,
    input wire logic                i_sys_rst,
    input wire rstwd_pkg::rst_src_t i_sources,
    input wire logic [2:0]          i_brownout_level_fuse,
    input wire logic                i_wdog_force_on_fuse,
    input wire logic                i_psel,
    input wire logic                i_penable,
    input wire logic                i_pwrite,
    input wire logic [11:0]         i_paddr,
    input wire logic                o_pready,
    input wire logic                o_pslverr,
    input wire logic [31:0]         o_prdata,
    input wire logic                o_port_reset,
    input wire logic                o_core_reset,
    input wire logic                o_wdog_irq,
    input wire logic                o_bandgap_enable
);
    // ============================================================
    // helpers: a brown-out input only counts while the detector is fused on
    wire logic bo_on = i_brownout_level_fuse != 3'h7;
    wire logic src_on = i_sources.supply_low | i_sources.ext_pin_low
        | i_sources.test_port_rst | (i_sources.brownout_low & bo_on);
    wire logic acc = i_psel & i_penable;
    wire logic rd_ctl = acc & !i_pwrite & (i_paddr == ADDR_WDOG_CTRL);
    wire logic mapped = i_paddr inside {ADDR_WDOG_CTRL, ADDR_RST_STATUS,
        ADDR_ANALOG_CTRL, ADDR_WDOG_CMD};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    // ============================================================
    // assertions
    src_drives_port_a: assert property (src_on |-> o_port_reset)
        else $error("port reset low while a source is active");
    src_holds_core_a: assert property (src_on |-> o_core_reset)
        else $error("core reset low while a source is active");
    release_stretch_a: assert property ($fell(src_on) |-> o_core_reset [*8])
        else $error("core reset released without the delay count");
    bandgap_fused_a: assert property (bo_on |-> o_bandgap_enable)
        else $error("bandgap off while brown-out detection is fused on");
    ready_now_a: assert property (acc |-> o_pready)
        else $error("access phase not answered at once");
    unmapped_err_a: assert property (acc && !mapped |-> o_pslverr && (i_pwrite || o_prdata == 0))
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !o_pslverr)
        else $error("mapped access refused");
    force_fuse_a: assert property (rd_ctl && i_wdog_force_on_fuse |->
        o_prdata[WDC_RST_ENABLE] && !o_prdata[WDC_IRQ_ENABLE]) else $error("fuse lock not shown");
    irq_cleared_a: assert property (o_core_reset [*2] |-> !o_wdog_irq)
        else $error("watchdog irq survives internal reset");
endmodule // rstwd_monitor
bind reset_and_watchdog_control rstwd_monitor u_monitor (.*);
`default_nettype wire

// [core_model.sv]
// core model: firmware side apb master issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        i_clock,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    input  wire logic [31:0] i_prdata,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [11:0]      o_paddr,
    output logic [31:0]      o_pwdata
);
    logic hung;
    // idle bus at time zero
    initial begin
        hung = 1'b0;
        o_psel = 1'b0;
        o_penable = 1'b0;
        o_pwrite = 1'b0;
        o_paddr = 12'h0;
        o_pwdata = 32'h0;
    end
    // setup, then access held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int k;
        @(posedge i_clock);
        o_psel <= 1'b1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_clock);
        o_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (i_pready !== 1'b1 && k < 64);
        hung |= (i_pready !== 1'b1);
        r = i_prdata;
        e = i_pslverr;
        o_psel <= 1'b0;
        o_penable <= 1'b0;
        // released lines flip so a stale value cannot pass for a live one
        o_paddr <= ~a;
        o_pwdata <= ~d;
    endtask
endmodule // core_model
`default_nettype wire

// [reset_and_watchdog_control_test.sv]
// testbench: reset source and watchdog register sequences
`timescale 1ns/1ps
`default_nettype none
module reset_and_watchdog_control_test;
    import rstwd_pkg::*;
    // signals named as the design ports so the instance connects by name
    logic        i_clock, i_sys_rst, i_wdog_force_on_fuse, i_psel, i_penable, i_pwrite;
    rst_src_t    i_sources;
    logic [2:0]  i_brownout_level_fuse;
    logic [1:0]  i_startup_time_fuse;
    logic [3:0]  i_clock_select_fuse;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rdat;
    logic        o_pready, o_pslverr, o_port_reset, o_core_reset, o_wdog_irq, o_bandgap_enable;
    logic        err;
    int          miscompares, tests_run, n, dly;
    int          cause_pos [4] = '{RS_SUPPLY, RS_EXTERNAL, RS_BROWNOUT, RS_TEST_PORT};
    reset_and_watchdog_control dut (.*);
    core_model u_core (.i_clock(i_clock), .i_pready(o_pready), .i_pslverr(o_pslverr),
        .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
        .o_paddr(i_paddr), .o_pwdata(i_pwdata));
    always #50 i_clock = ~i_clock;
    // ============================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_core.xfer(1'b1, a, d, rdat, err);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        u_core.xfer(1'b0, a, 32'h0, rdat, err);
        chk(rdat, exp);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // counts cycles of stretched reset; bounded so a stuck reset ends the run
    task automatic wait_rel();
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_core_reset !== 1'b0 && n < 3000);
        chk(n < 3000, 1'b1);
        if (n >= 3000) finish_test();
    endtask
    // ============================================================
    // main sequence
    initial begin
        i_clock = 1'b0;
        i_sys_rst = 1'b1;
        i_sources = 4'h8;
        i_brownout_level_fuse = 3'h7;
        i_startup_time_fuse = 2'h0;
        i_clock_select_fuse = 4'h0;
        i_wdog_force_on_fuse = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (3) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        @(posedge i_clock);
        i_sources <= 4'h0;
        wait_rel();
        // each of the four input sources alone, with fuse-chosen stretches of 64, 256, 256 and 1024 cycles
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_RST_STATUS, 32'h0);
            i_brownout_level_fuse <= 3'h0;
            i_startup_time_fuse <= 2'(i);
            i_clock_select_fuse <= 4'(i % 2);
            i_sources <= 4'(8 >> i);
            @(negedge i_clock);
            chk(o_port_reset, 1'b1);
            @(posedge i_clock);
            i_sources <= 4'h0;
            dly = RELEASE_DELAY_CYC << (i + i % 2);
            wait_rel();
            chk(n >= dly && n <= dly + 3, 1'b1);
            rd(ADDR_RST_STATUS, 32'h1 << cause_pos[i]);
        end
        $display("test sources done");
        // detector fused off ignores a brown-out; bandgap follows each request
        i_brownout_level_fuse <= 3'h7;
        i_sources <= 4'h2;
        @(negedge i_clock);
        chk(o_port_reset, 1'b0);
        chk(o_bandgap_enable, 1'b0);
        for (int j = 1; j < 4; j++) begin
            wr(ADDR_ANALOG_CTRL, 32'(j));
            @(negedge i_clock);
            chk(o_bandgap_enable, 1'b1);
        end
        $display("test bandgap done");
        // protected watchdog fields: refused, unlocked, window expiry
        wr(ADDR_WDOG_CTRL, 32'h08);
        wr(ADDR_WDOG_CTRL, 32'h03);
        rd(ADDR_WDOG_CTRL, 32'h08);
        wr(ADDR_WDOG_CTRL, 32'h1D);
        wr(ADDR_WDOG_CTRL, 32'h05);
        rd(ADDR_WDOG_CTRL, 32'h05);
        wr(ADDR_WDOG_CTRL, 32'h1D);
        rd(ADDR_WDOG_CTRL, 32'h1D);
        repeat (4) @(posedge i_clock);
        rd(ADDR_WDOG_CTRL, 32'h0D);
        wr(ADDR_WDOG_CTRL, 32'h40);
        rd(ADDR_WDOG_CTRL, 32'h4D);
        chk(o_wdog_irq, 1'b0);
        i_wdog_force_on_fuse <= 1'b1;
        rd(ADDR_WDOG_CTRL, 32'h0D);
        i_wdog_force_on_fuse <= 1'b0;
        wr(ADDR_WDOG_CMD, 32'h3);
        rd(ADDR_WDOG_CMD, 32'h0);
        rd(12'h010, 32'h0);
        chk(err, 1'b1);
        $display("test watchdog done");
        // internal reset from the pin clears watchdog and analog settings
        i_sources <= 4'h4;
        @(posedge i_clock);
        i_sources <= 4'h0;
        wait_rel();
        chk(o_bandgap_enable, 1'b0);
        rd(ADDR_WDOG_CTRL, 32'h0);
        chk(u_core.hung, 1'b0);
        $display("test internal reset done");
        finish_test();
    end
endmodule // reset_and_watchdog_control_test
`default_nettype wire
